//--- src/tsa_params.svh
/*
  Constants of the teletext RAM slot arbiter: widths, counts, field
  positions and reset values. Assumes nothing; definitions only.
*/
`ifndef TSA_PARAMS_SVH
`define TSA_PARAMS_SVH

// ----------------------------------------------------------------
// widths and slot cycle
// ----------------------------------------------------------------
`define TSA_ADDR_W 13
`define TSA_DATA_W 8
`define TSA_SLOTS 8
`define TSA_SLOT_LAST 3'h7
`define TSA_RAM_CLK_NS 10

// ----------------------------------------------------------------
// block transfer buffer
// ----------------------------------------------------------------
`define TSA_BUF_BYTES 40
`define TSA_BUF_LAST 6'h27
`define TSA_ADDR_STEP 13'h0028
`define TSA_MODE_REJECT 0
`define TSA_MODE_CANCEL 1
`define TSA_MODE_READ 2

// ----------------------------------------------------------------
// field split and buffering
// ----------------------------------------------------------------
`define TSA_STORE_LAST_LINE 9'h018
`define TSA_STORE_LAST_LINE_DBL 9'h031
`define TSA_FIFO_DEPTH 32

// ----------------------------------------------------------------
// reset values
// ----------------------------------------------------------------
`define TSA_RST_ADDR 13'h0000
`define TSA_RST_MODE 3'h4
`define TSA_RST_LINE 9'h000

`endif

//--- src/tsa_pkg.sv
/*
  Types shared by the slot arbiter modules: slot kinds, slot owners,
  sequencer states and the packed carriers for acquisition words and
  RAM commands. Assumes tsa_params.svh is on the include path.
*/
`include "tsa_params.svh"

package tsa_pkg;

  // ----------------------------------------------------------------
  // enumerations
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {
    KIND_SHARED = 2'h0,
    KIND_CPU = 2'h1,
    KIND_XFER = 2'h2
  } tsa_kind_t;

  typedef enum logic [2:0] {
    OWN_NONE = 3'h0,
    OWN_STORE = 3'h1,
    OWN_SHOW = 3'h2,
    OWN_XFER = 3'h3,
    OWN_CPU = 3'h4
  } tsa_owner_t;

  typedef enum logic {
    SEQ_IDLE = 1'b0,
    SEQ_RUN = 1'b1
  } tsa_seq_state_t;

  // ----------------------------------------------------------------
  // carriers
  // ----------------------------------------------------------------
  typedef struct packed {
    logic [`TSA_ADDR_W-1:0] addr;
    logic [`TSA_DATA_W-1:0] data;
  } tsa_store_word_t;

  typedef struct packed {
    logic en;
    logic we;
    logic [`TSA_ADDR_W-1:0] addr;
    logic [`TSA_DATA_W-1:0] wdata;
  } tsa_ram_cmd_t;

endpackage

//--- src/tsa_fifo.sv
/*
  Synchronous FIFO of flip-flops with valid/ready on both sides.
  Assumes one clock, synchronous active-high reset, DEPTH >= 2.
*/
`timescale 1ns/100ps

module tsa_fifo #(
  parameter int WIDTH = 21,
  parameter int DEPTH = 32
) (
  input wire logic core_clk,
  input wire logic srst,
  input wire logic in_valid,
  input wire logic [WIDTH-1:0] in_data,
  output logic in_ready,
  output logic out_valid,
  output logic [WIDTH-1:0] out_data,
  input wire logic out_ready
);

  localparam int AW = $clog2(DEPTH);
  localparam logic [AW:0] FULL = (AW+1)'(DEPTH);
  localparam logic [AW-1:0] PTR_LAST = AW'(DEPTH - 1);

  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0] wr_ptr;
  logic [AW-1:0] rd_ptr;
  logic [AW:0] count;
  logic [AW:0] next_count;
  wire push = in_valid & in_ready;
  wire pop = out_valid & out_ready;

  // occupancy and the flags derived from it
  assign next_count = count + (AW+1)'(push) - (AW+1)'(pop);
  assign out_data = mem[rd_ptr];

  // pointers and registered flags
  always_ff @(posedge core_clk) begin
    if (srst) begin
      wr_ptr <= '0;
      rd_ptr <= '0;
      count <= '0;
      in_ready <= 1'b1;
      out_valid <= 1'b0;
    end else begin
      if (push) wr_ptr <= (wr_ptr == PTR_LAST) ? '0 : wr_ptr + 1'b1;
      if (pop) rd_ptr <= (rd_ptr == PTR_LAST) ? '0 : rd_ptr + 1'b1;
      count <= next_count;
      in_ready <= (next_count != FULL);
      out_valid <= (next_count != '0);
    end
  end

  // storage
  always_ff @(posedge core_clk) begin
    if (push) mem[wr_ptr] <= in_data;
  end

endmodule

//--- src/tsa_slot_seq.sv
/*
  Slot sequencer: runs the eight-slot cycle, restarts it on each line
  start and counts lines to split the field between storing and showing.
  Assumes line_start and field_start are one-cycle pulses on core_clk.
*/
`timescale 1ns/100ps

module tsa_slot_seq
  import tsa_pkg::*;
(
  input wire logic core_clk,
  input wire logic srst,
  input wire logic enable,
  input wire logic line_start,
  input wire logic field_start,
  input wire logic double_scan,
  output logic slot_valid,
  output logic [2:0] slot_idx,
  output logic store_phase
);

  tsa_seq_state_t state;
  tsa_seq_state_t next_state;
  logic [2:0] next_idx;
  logic [8:0] line;
  logic [8:0] next_line;
  wire [8:0] last_line = double_scan ? `TSA_STORE_LAST_LINE_DBL : `TSA_STORE_LAST_LINE;

  // ----------------------------------------------------------------
  // slot cycle
  // ----------------------------------------------------------------
  // idle while disabled, restart at slot 0 after the running slot
  always_comb begin
    next_state = state;
    next_idx = slot_idx;
    case (state)
      SEQ_IDLE: begin
        next_idx = 3'h0;
        if (enable) next_state = SEQ_RUN;
      end
      SEQ_RUN: begin
        if (!enable) begin
          next_state = SEQ_IDLE;
          next_idx = 3'h0;
        end else if (line_start) begin
          next_idx = 3'h0;
        end else begin
          next_idx = slot_idx + 3'h1;
        end
      end
      default: begin
        next_state = SEQ_IDLE;
        next_idx = 3'h0;
      end
    endcase
  end

  // line count within the field, saturating
  assign next_line = field_start ? 9'h001 :
                     (line_start && line != 9'h1ff) ? line + 9'h001 : line;
  assign slot_valid = (state == SEQ_RUN);
  assign store_phase = (line != 9'h000) && (line <= last_line);

  always_ff @(posedge core_clk) begin
    if (srst) begin
      state <= SEQ_IDLE;
      slot_idx <= 3'h0;
      line <= `TSA_RST_LINE;
    end else begin
      state <= next_state;
      slot_idx <= next_idx;
      line <= next_line;
    end
  end

endmodule

//--- src/tsa_ram_slot_arbiter.sv
/*
  Slot arbiter for the teletext/display RAM: one byte-wide RAM port
  shared by acquisition storing, display reading, a 40-byte block
  transfer buffer and direct CPU access, with CPU wait on contention.
  Assumes core_clk is the RAM clock (dot clock / 2), a synchronous RAM
  whose read data is valid the cycle after ram_cmd is presented, and
  sync pins that are asynchronous to core_clk.
*/
// Function
// - eight one-byte slots repeat each line
// - line sync ends slot, restarts cycle
// - storing slot writes acquisition byte
// - display slot reads byte for display
// - transfer slot moves one buffer byte
// - CPU slot exchanges byte at CPU address
// - storing until line 24 (line 49 with double_scan), then display
// - CPU waits until its slot serves it
// - wait length follows slot distance
// - CPU slot within one or two slots
// - reset leaves sequencer idle, RAM disabled
// - setting busy starts a 40-byte transfer
// - 13-bit start address steps up or down
// - buffer locked while busy, busy self-clears
// - transfers cover 40 consecutive RAM bytes
// - reject mode skips bytes with bad parity
// - cancel mode clears top bit written
// - parity checked before top bit cleared
// - odd count of ones is good parity
// - sticky parity flag set on write errors
// - transfer mode decoded and latched at start
// - interface off: no accesses, no waits
// - start address moves by 40 after transfer
// - buffer exchange runs byte 0 to 39
`timescale 1ns/100ps
`include "tsa_params.svh"

module tsa_ram_slot_arbiter
  import tsa_pkg::*;
#(
  parameter int FIFO_DEPTH = `TSA_FIFO_DEPTH
) (
  input wire logic core_clk,
  input wire logic srst,
  input wire logic hsync_pin,
  input wire logic vsync_pin,
  input wire logic interface_enable,
  input wire logic acquisition_enable,
  input wire logic display_enable,
  input wire logic double_scan,
  input wire logic address_direction,
  input wire logic [2:0] transfer_mode,
  input wire logic busy_set,
  input wire logic parity_flag_clear,
  input wire logic start_addr_load,
  input wire logic [`TSA_ADDR_W-1:0] start_addr_in,
  output logic busy,
  output logic parity_error_flag,
  output logic [`TSA_ADDR_W-1:0] start_addr,
  input wire logic [5:0] buf_index,
  input wire logic buf_write,
  input wire logic [`TSA_DATA_W-1:0] buf_wdata,
  output logic [`TSA_DATA_W-1:0] buf_rdata,
  input wire logic acquisition_valid,
  input wire tsa_store_word_t acquisition_word,
  output logic acquisition_ready,
  input wire logic [`TSA_ADDR_W-1:0] display_addr,
  output logic [`TSA_DATA_W-1:0] display_data,
  output logic display_valid,
  input wire logic cpu_req,
  input wire logic cpu_we,
  input wire logic [`TSA_ADDR_W-1:0] cpu_addr,
  input wire logic [`TSA_DATA_W-1:0] cpu_wdata,
  output logic [`TSA_DATA_W-1:0] cpu_rdata,
  output logic cpu_ack,
  output logic cpu_wait,
  output tsa_ram_cmd_t ram_cmd,
  input wire logic [`TSA_DATA_W-1:0] ram_rdata
);

  // ----------------------------------------------------------------
  // sync pin capture
  // ----------------------------------------------------------------
  logic [2:0] hs_sync;
  logic [2:0] vs_sync;
  wire line_start = hs_sync[1] & ~hs_sync[2];
  wire field_start = vs_sync[1] & ~vs_sync[2];

  // two-stage synchronisers plus one stage for edge detection
  always_ff @(posedge core_clk) begin
    if (srst) begin
      hs_sync <= 3'h0;
      vs_sync <= 3'h0;
    end else begin
      hs_sync <= {hs_sync[1:0], hsync_pin};
      vs_sync <= {vs_sync[1:0], vsync_pin};
    end
  end

  // ----------------------------------------------------------------
  // sequencer and acquisition buffering
  // ----------------------------------------------------------------
  logic slot_valid;
  logic [2:0] slot_idx;
  logic store_phase;
  logic fifo_valid;
  tsa_store_word_t fifo_word;
  tsa_owner_t owner;

  tsa_slot_seq u_seq (
    .core_clk(core_clk),
    .srst(srst),
    .enable(interface_enable),
    .line_start(line_start),
    .field_start(field_start),
    .double_scan(double_scan),
    .slot_valid(slot_valid),
    .slot_idx(slot_idx),
    .store_phase(store_phase)
  );

  tsa_fifo #(
    .WIDTH($bits(tsa_store_word_t)),
    .DEPTH(FIFO_DEPTH)
  ) u_fifo (
    .core_clk(core_clk),
    .srst(srst),
    .in_valid(acquisition_valid),
    .in_data(acquisition_word),
    .in_ready(acquisition_ready),
    .out_valid(fifo_valid),
    .out_data(fifo_word),
    .out_ready(owner == OWN_STORE)
  );

  // ----------------------------------------------------------------
  // slot ownership
  // ----------------------------------------------------------------
  logic [5:0] xfer_cnt;
  logic [2:0] xfer_mode;
  logic xfer_dir;
  logic cpu_inflight;
  logic [`TSA_DATA_W-1:0] buffer [`TSA_BUF_BYTES];
  tsa_kind_t kind;

  // fixed order: shared, cpu, transfer, cpu, repeated twice
  assign kind = slot_idx[0] ? KIND_CPU : (slot_idx[1] ? KIND_XFER : KIND_SHARED);
  wire store_use = store_phase & acquisition_enable & fifo_valid;
  wire show_use = ~store_phase & display_enable;
  wire issue_done = (xfer_cnt == `TSA_BUF_LAST + 6'h1);
  wire xfer_use = busy & ~issue_done;
  wire cpu_use = cpu_req & ~cpu_inflight & ~cpu_ack;

  // idle or disabled units hand their slot to the CPU
  assign owner = !slot_valid ? OWN_NONE :
                 (kind == KIND_SHARED && store_use) ? OWN_STORE :
                 (kind == KIND_SHARED && show_use) ? OWN_SHOW :
                 (kind == KIND_XFER && xfer_use) ? OWN_XFER :
                 cpu_use ? OWN_CPU : OWN_NONE;

  // ----------------------------------------------------------------
  // transfer byte path
  // ----------------------------------------------------------------
  wire [5:0] xfer_idx = issue_done ? `TSA_BUF_LAST : xfer_cnt;
  wire [`TSA_DATA_W-1:0] xfer_byte = buffer[xfer_idx];
  wire xfer_wr = ~xfer_mode[`TSA_MODE_READ];
  wire xfer_par_ok = ^xfer_byte;
  wire xfer_skip = xfer_wr & xfer_mode[`TSA_MODE_REJECT] & ~xfer_par_ok;
  wire [`TSA_DATA_W-1:0] xfer_wdata =
    xfer_mode[`TSA_MODE_CANCEL] ? {1'b0, xfer_byte[6:0]} : xfer_byte;
  wire [`TSA_ADDR_W-1:0] xfer_off = {7'h00, xfer_cnt};
  wire [`TSA_ADDR_W-1:0] xfer_addr =
    xfer_dir ? start_addr - xfer_off : start_addr + xfer_off;

  // ----------------------------------------------------------------
  // RAM command selection
  // ----------------------------------------------------------------
  tsa_ram_cmd_t next_cmd;
  tsa_owner_t rd_owner;
  tsa_owner_t tag0;
  tsa_owner_t tag1;
  logic [5:0] tidx0;
  logic [5:0] tidx1;
  wire sel_en = (owner != OWN_NONE) && !(owner == OWN_XFER && xfer_skip);
  wire sel_we = (owner == OWN_STORE) || (owner == OWN_XFER && xfer_wr) ||
                (owner == OWN_CPU && cpu_we);
  wire [`TSA_ADDR_W-1:0] sel_addr =
    (owner == OWN_STORE) ? fifo_word.addr :
    (owner == OWN_SHOW) ? display_addr :
    (owner == OWN_XFER) ? xfer_addr : cpu_addr;
  wire [`TSA_DATA_W-1:0] sel_wdata =
    (owner == OWN_STORE) ? fifo_word.data :
    (owner == OWN_XFER) ? xfer_wdata : cpu_wdata;

  assign next_cmd = '{en: sel_en, we: sel_we, addr: sel_addr, wdata: sel_wdata};
  assign rd_owner = (sel_en && !sel_we) ? owner : OWN_NONE;

  // command register and read-return tags
  always_ff @(posedge core_clk) begin
    if (srst) begin
      ram_cmd <= '0;
      tag0 <= OWN_NONE;
      tag1 <= OWN_NONE;
      tidx0 <= 6'h00;
      tidx1 <= 6'h00;
    end else begin
      ram_cmd <= next_cmd;
      tag0 <= rd_owner;
      tag1 <= tag0;
      tidx0 <= xfer_cnt;
      tidx1 <= tidx0;
    end
  end

  // ----------------------------------------------------------------
  // CPU and display answers
  // ----------------------------------------------------------------
  wire cpu_take = (owner == OWN_CPU);
  wire cpu_back = (tag1 == OWN_CPU);
  wire next_cpu_ack = (cpu_take & cpu_we) | cpu_back;
  wire next_cpu_wait = interface_enable & cpu_req & ~next_cpu_ack & ~cpu_ack;

  always_ff @(posedge core_clk) begin
    if (srst) begin
      cpu_inflight <= 1'b0;
      cpu_ack <= 1'b0;
      cpu_wait <= 1'b0;
      cpu_rdata <= 8'h00;
      display_valid <= 1'b0;
      display_data <= 8'h00;
    end else begin
      cpu_inflight <= (cpu_take & ~cpu_we) | (cpu_inflight & ~cpu_back);
      cpu_ack <= next_cpu_ack;
      cpu_wait <= next_cpu_wait;
      if (cpu_back) cpu_rdata <= ram_rdata;
      display_valid <= (tag1 == OWN_SHOW);
      if (tag1 == OWN_SHOW) display_data <= ram_rdata;
    end
  end

  // ----------------------------------------------------------------
  // block transfer control
  // ----------------------------------------------------------------
  wire xfer_issue = (owner == OWN_XFER);
  wire xfer_back = (tag1 == OWN_XFER);
  wire xfer_start = busy_set & ~busy;
  wire xfer_finish = (xfer_issue & xfer_wr & (xfer_cnt == `TSA_BUF_LAST)) |
                     (xfer_back & (tidx1 == `TSA_BUF_LAST));
  wire next_busy = xfer_start | (busy & ~xfer_finish);
  wire [5:0] next_cnt = xfer_start ? 6'h00 : xfer_issue ? xfer_cnt + 6'h01 : xfer_cnt;
  wire pef_set = xfer_issue & xfer_wr & ~xfer_par_ok;
  wire next_pef = pef_set | (parity_error_flag & ~parity_flag_clear);
  wire [`TSA_ADDR_W-1:0] step_addr =
    xfer_dir ? start_addr - `TSA_ADDR_STEP : start_addr + `TSA_ADDR_STEP;
  wire [`TSA_ADDR_W-1:0] next_start_addr =
    (start_addr_load & ~busy) ? start_addr_in :
    xfer_finish ? step_addr : start_addr;

  always_ff @(posedge core_clk) begin
    if (srst) begin
      busy <= 1'b0;
      xfer_cnt <= 6'h00;
      xfer_mode <= `TSA_RST_MODE;
      xfer_dir <= 1'b0;
      parity_error_flag <= 1'b0;
      start_addr <= `TSA_RST_ADDR;
    end else begin
      busy <= next_busy;
      xfer_cnt <= next_cnt;
      if (xfer_start) xfer_mode <= transfer_mode;
      if (xfer_start) xfer_dir <= address_direction;
      parity_error_flag <= next_pef;
      start_addr <= next_start_addr;
    end
  end

  // ----------------------------------------------------------------
  // transfer buffer storage
  // ----------------------------------------------------------------
  wire sw_hit = buf_write & ~busy & (buf_index <= `TSA_BUF_LAST);

  // software writes while idle, RAM read data fills during a transfer
  for (genvar i = 0; i < `TSA_BUF_BYTES; i++) begin : g_buf
    wire sw_wr = sw_hit & (buf_index == 6'(i));
    wire ram_wr = xfer_back & (tidx1 == 6'(i));
    always_ff @(posedge core_clk) begin
      if (sw_wr) buffer[i] <= buf_wdata;
      else if (ram_wr) buffer[i] <= ram_rdata;
    end
  end

  // locked buffer reads as zero
  always_ff @(posedge core_clk) begin
    if (srst) buf_rdata <= 8'h00;
    else buf_rdata <= (busy || buf_index > `TSA_BUF_LAST) ? 8'h00 : buffer[buf_index];
  end

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (srst);

  sequence s_show_issue;
    owner == OWN_SHOW ##1 (ram_cmd.en && !ram_cmd.we);
  endsequence

  sequence s_cpu_stalled;
    $rose(cpu_wait) && interface_enable;
  endsequence

  slot_step_a: assert property (
    slot_valid && interface_enable && !line_start && slot_idx != `TSA_SLOT_LAST
    |=> slot_valid && slot_idx == $past(slot_idx) + 3'h1)
    else $error("slot did not advance");
  line_restart_a: assert property (
    line_start && interface_enable |=> slot_valid && slot_idx == 3'h0)
    else $error("cycle not restarted on line start");
  store_write_a: assert property (
    owner == OWN_STORE |=> ram_cmd.en && ram_cmd.we && ram_cmd.addr == $past(fifo_word.addr))
    else $error("storing slot did not write");
  show_read_a: assert property (
    s_show_issue |-> ##2 display_valid)
    else $error("display byte not delivered");
  cpu_wait_bound_a: assert property (
    s_cpu_stalled |-> ##[1:8] !cpu_wait)
    else $error("cpu stall too long");
  reset_idle_a: assert property (
    disable iff (1'b0) srst |=> !ram_cmd.en && !slot_valid && !busy && !cpu_wait)
    else $error("not idle after reset");
  enable_off_a: assert property (
    !interface_enable [*2] |=> !ram_cmd.en && !cpu_wait)
    else $error("access while interface off");
  reject_skip_a: assert property (
    owner == OWN_XFER && xfer_skip |=> !ram_cmd.en)
    else $error("bad parity byte written");
  cancel_top_a: assert property (
    owner == OWN_XFER && xfer_wr && xfer_mode[`TSA_MODE_CANCEL] |=> !ram_cmd.wdata[7])
    else $error("top bit not cleared");
  parity_flag_a: assert property (
    pef_set |=> parity_error_flag)
    else $error("parity flag not set");
  busy_done_a: assert property (
    xfer_finish |=> !busy && start_addr == ($past(xfer_dir) ?
      $past(start_addr) - `TSA_ADDR_STEP : $past(start_addr) + `TSA_ADDR_STEP))
    else $error("transfer end wrong");

endmodule

//--- test/tsa_ram_model.sv
/*
  RAM model at the arbiter's memory port: 8K bytes, read data one
  cycle after the command. Assumes ram_cmd is registered on core_clk.
*/
`timescale 1ns/100ps

module tsa_ram_model
  import tsa_pkg::*;
(
  input wire logic core_clk,
  input wire tsa_ram_cmd_t ram_cmd,
  output logic [7:0] ram_rdata
);
  logic [7:0] mem [0:8191];

  // preset pattern derived from the address
  initial begin
    for (int i = 0; i < 8192; i++) begin
      mem[i] = 8'(i) ^ 8'h5a;
    end
    ram_rdata = 8'h00;
  end

  // write at once, read data next cycle, otherwise a toggling pattern
  always @(posedge core_clk) begin
    if (ram_cmd.en === 1'b1 && ram_cmd.we === 1'b1) begin
      mem[ram_cmd.addr] <= ram_cmd.wdata;
    end
    if (ram_cmd.en === 1'b1 && ram_cmd.we === 1'b0) begin
      ram_rdata <= mem[ram_cmd.addr];
    end else begin
      ram_rdata <= ~ram_rdata;
    end
  end
endmodule

//--- test/test_tsa_ram_slot_arbiter.sv
/*
  Bench of the RAM slot arbiter: idle and off states, acquisition FIFO,
  CPU and display slots, block transfers. Assumes the design files and
  the RAM model are compiled first.
*/
`timescale 1ns/100ps

module test_tsa_ram_slot_arbiter
  import tsa_pkg::*;
;
  // --------------------------------
  // signals and instances
  // --------------------------------
  logic core_clk = 1'b0, srst = 1'b1, hsync_pin = 1'b0, vsync_pin = 1'b0;
  logic interface_enable = 1'b0, acquisition_enable = 1'b0, display_enable = 1'b0;
  logic double_scan = 1'b0, address_direction = 1'b0, busy_set = 1'b0;
  logic parity_flag_clear = 1'b0, start_addr_load = 1'b0, buf_write = 1'b0;
  logic acquisition_valid = 1'b0, cpu_req = 1'b0, cpu_we = 1'b0, wait_seen = 1'b0;
  logic busy, parity_error_flag, acquisition_ready, display_valid, cpu_ack, cpu_wait;
  logic [2:0] transfer_mode = 3'h4;
  logic [5:0] buf_index = 6'h00;
  logic [7:0] buf_wdata = 8'h00, cpu_wdata = 8'h00;
  logic [7:0] buf_rdata, display_data, cpu_rdata, ram_rdata;
  logic [12:0] start_addr_in = 13'h0000, display_addr = 13'h0010, cpu_addr = 13'h0000;
  logic [12:0] start_addr;
  tsa_store_word_t acquisition_word = '0;
  tsa_ram_cmd_t ram_cmd;
  int error_cnt = 0, checks_done = 0, ram_ops = 0;

  tsa_ram_slot_arbiter tsa_ram_slot_arbiter_inst (.*);
  tsa_ram_model tsa_ram_model_inst (.core_clk, .ram_cmd, .ram_rdata);

  // clock and count of RAM commands
  always #5 core_clk = ~core_clk;
  always @(posedge core_clk) if (ram_cmd.en === 1'b1) ram_ops <= ram_ops + 1;

  // --------------------------------
  // helpers
  // --------------------------------
  function automatic logic [7:0] bv(int k);
    return 8'(k) * 8'h0b + 8'h81;
  endfunction
  function automatic logic [7:0] old(int a);
    return 8'(a) ^ 8'h5a;
  endfunction
  function automatic tsa_store_word_t mk(int i);
    return {13'(4096 + i), 8'(i) ^ 8'h33};
  endfunction
  // byte left in RAM by a write transfer
  function automatic logic [7:0] wexp(int m, int k, int a);
    logic [7:0] b;
    b = bv(k);
    if (m[0] && !(^b)) return old(a);
    return m[1] ? {1'b0, b[6:0]} : b;
  endfunction

  task automatic check(input logic [12:0] seen, input logic [12:0] exp_v, input string msg);
    checks_done++;
    if (seen !== exp_v) begin
      error_cnt++;
      $display("BAD %0t %s: seen %h expected %h", $time, msg, seen, exp_v);
    end
  endtask

  task automatic conclude();
    $display("checks %0d mismatches %0d", checks_done, error_cnt);
    if (error_cnt == 0 && checks_done > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask

  // request held until acknowledged or 20 cycles pass, dropped the cycle after
  task automatic cpu_access(input logic we, input logic [12:0] a, input logic [7:0] d,
                            output logic [7:0] q, output int n);
    @(posedge core_clk);
    cpu_req <= 1'b1;
    cpu_we <= we;
    cpu_addr <= a;
    cpu_wdata <= d;
    n = 0;
    do begin
      @(posedge core_clk);
      #1;
      n++;
      wait_seen |= cpu_wait;
    end while (cpu_ack !== 1'b1 && n < 20);
    q = cpu_rdata;
    @(posedge core_clk);
    cpu_req <= 1'b0;
  endtask

  task automatic sync_pulse(input logic v);
    @(posedge core_clk);
    vsync_pin <= v;
    hsync_pin <= ~v;
    repeat (4) @(posedge core_clk);
    vsync_pin <= 1'b0;
    hsync_pin <= 1'b0;
    repeat (4) @(posedge core_clk);
  endtask

  task automatic run_xfer(input logic [2:0] m, input logic dn, input logic [12:0] a);
    int n;
    @(posedge core_clk);
    transfer_mode <= m;
    address_direction <= dn;
    start_addr_in <= a;
    start_addr_load <= 1'b1;
    parity_flag_clear <= 1'b1;
    @(posedge core_clk);
    start_addr_load <= 1'b0;
    parity_flag_clear <= 1'b0;
    busy_set <= 1'b1;
    @(posedge core_clk);
    busy_set <= 1'b0;
    transfer_mode <= ~m;
    @(posedge core_clk);
    #1;
    check(busy, 1'h1, "busy");
    check(buf_rdata, 8'h00, "buffer locked");
    for (n = 0; n < 1000 && busy === 1'b1; n++) begin
      @(posedge core_clk);
      #1;
    end
    // last command lands in the RAM model one edge after busy drops
    repeat (2) @(posedge core_clk);
    #1;
    check(start_addr, dn ? a - 13'h0028 : a + 13'h0028, "next start");
  endtask

  // --------------------------------
  // scenarios
  // --------------------------------
  task automatic t_idle();
    logic [7:0] q;
    int n;
    check(busy | ram_cmd.en | cpu_ack | display_valid, 1'h0, "idle");
    check(start_addr, 13'h0000, "addr reset");
    cpu_access(1'b0, 13'h0040, 8'h00, q, n);
    check(n, 13'h0014, "off refused");
    check(wait_seen | (ram_ops != 0), 1'h0, "off quiet");
    $display("test idle done");
  endtask

  task automatic t_acq();
    int cnt = 0;
    @(posedge core_clk);
    acquisition_valid <= 1'b1;
    acquisition_word <= mk(0);
    repeat (40) begin
      @(posedge core_clk);
      if (acquisition_ready === 1'b1) acquisition_word <= mk(++cnt);
    end
    acquisition_valid <= 1'b0;
    check(13'(cnt), 13'h0020, "fifo fill");
    @(posedge core_clk);
    acquisition_enable <= 1'b1;
    @(posedge core_clk);
    interface_enable <= 1'b1;
    sync_pulse(1'b1);
    sync_pulse(1'b0);
    for (int n = 0; n < 1000 && tsa_ram_model_inst.mem[4127] !== 8'h2c; n++) begin
      @(posedge core_clk);
    end
    for (int i = 0; i < 32; i++) begin
      check(tsa_ram_model_inst.mem[4096 + i], 8'(i) ^ 8'h33, "stored");
    end
    @(posedge core_clk);
    interface_enable <= 1'b0;
    @(posedge core_clk);
    acquisition_enable <= 1'b0;
    display_enable <= 1'b1;
    @(posedge core_clk);
    interface_enable <= 1'b1;
    repeat (24) sync_pulse(1'b0);
    $display("test acq done");
  endtask

  task automatic t_cpu();
    logic [7:0] q;
    int n;
    cpu_access(1'b1, 13'h0123, 8'hc3, q, n);
    check(n <= 6, 1'h1, "write wait");
    cpu_access(1'b0, 13'h0123, 8'h00, q, n);
    check(q, 8'hc3, "cpu read");
    check(n <= 8, 1'h1, "read wait");
    check(wait_seen, 1'h1, "stall seen");
    for (n = 0; n < 40 && display_valid !== 1'b1; n++) begin
      @(posedge core_clk);
      #1;
    end
    check(display_data, old(16), "display");
    $display("test cpu done");
  endtask

  task automatic t_xfer();
    int a;
    for (int k = 0; k < 40; k++) begin
      @(posedge core_clk);
      buf_index <= 6'(k);
      buf_wdata <= bv(k);
      buf_write <= 1'b1;
    end
    @(posedge core_clk);
    buf_write <= 1'b0;
    for (int m = 0; m < 4; m++) begin
      a = 512 + m * 64;
      run_xfer(3'(m), 1'b0, 13'(a));
      check(parity_error_flag, 1'h1, "parity flag");
      for (int k = 0; k < 40; k++) begin
        check(tsa_ram_model_inst.mem[a + k], wexp(m, k, a + k), "write");
      end
    end
    run_xfer(3'h4, 1'b1, 13'h0400);
    for (int k = 0; k < 40; k++) begin
      @(posedge core_clk);
      buf_index <= 6'(k);
      @(posedge core_clk);
      #1;
      check(buf_rdata, old(1024 - k), "read");
    end
    $display("test xfer done");
  endtask

  // reset, scenarios, verdict
  initial begin
    repeat (5) @(posedge core_clk);
    srst <= 1'b0;
    @(posedge core_clk);
    #1;
    t_idle();
    t_acq();
    t_cpu();
    t_xfer();
    conclude();
  end

  // watchdog well beyond the expected run
  initial begin
    #300000;
    error_cnt++;
    conclude();
  end
endmodule
